// ==== inc/sdl_pkg.sv ====
package sdl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_SEL = 0;
    localparam int IDX_LO = 1;
    localparam logic [2:0] IDX_CMD = 3'h0;
    localparam logic [2:0] IDX_MODE = 3'h1;
    localparam logic [2:0] IDX_SPECIAL = 3'h1;
    localparam logic [2:0] IDX_RXCTL = 3'h3;
    localparam logic [2:0] IDX_TXCTL = 3'h5;
    localparam logic [2:0] IDX_STATION = 3'h6;
    localparam int MODE_EXT_IE = 0;
    localparam int MODE_MIE = 1;
    localparam int MODE_RXI_LO = 3;
    localparam int MODE_DMA_RX = 5;
    localparam int MODE_DMA_EN = 7;
    localparam int RXCTL_EN = 0;
    localparam int TXCTL_CRC = 0;
    localparam int TXCTL_RTS = 1;
    localparam int TXCTL_EN = 3;
    localparam int SP_EOF = 0;
    localparam int SP_OVERRUN = 1;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] CMD_RST_EXT = 8'h10;
    localparam logic [7:0] CMD_RX_NEXT = 8'h20;
    localparam logic [7:0] CMD_RST_ERR = 8'h30;
    localparam logic [7:0] CMD_RST_UNDERRUN = 8'hC0;
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_CRC_ERR = 1;
    localparam int ST_TX_EMPTY = 2;
    localparam int ST_CARRIER = 3;
    localparam int ST_EOF = 4;
    localparam int ST_CTS = 5;
    localparam int ST_EOM = 6;
    localparam int ST_ABORT = 7;
    localparam logic [7:0] FLAG = 8'h7E;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;
    localparam logic [4:0] UNIT_BYTE = 5'h08;
    localparam logic [4:0] UNIT_CRC = 5'h10;
    localparam logic [2:0] ONES_STUFF = 3'h5;
    localparam logic [2:0] ONES_ABORT = 3'h6;
    localparam logic [2:0] RX_END_BITS = 3'h6;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        RXI_OFF = 2'b00,
        RXI_FIRST = 2'b01,
        RXI_ALL = 2'b10,
        RXI_SPECIAL = 2'b11
    } sdl_rxi_t;

    typedef enum logic [1:0] {
        TX_OFF = 2'b00,
        TX_FLAG = 2'b01,
        TX_DATA = 2'b10,
        TX_CRC = 2'b11
    } sdl_tx_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_ADDR = 2'b01,
        RX_DATA = 2'b10,
        RX_SKIP = 2'b11
    } sdl_rx_t;

    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
        crc_bit = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = crc_bit(r, d[i]);
        end
        crc_byte = r;
    endfunction
endpackage

// ==== verilog/sdl_link_channel.sv ====
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - no frame starts while line activity shown
// - receive data captured on opposite clock edge
// - transmit dma requests while buffer empty
// - receive dma requests while character held
// - end of message, crc error in status
// - external status changes and break interrupt
// - receive interrupt first, all, or special
// - command c0h resets transmit underrun latch
// - first byte matched against station address
// - idle flags 7eh sent between frames
// - status d2 shows transmit buffer empty
// - status d0 clears when fifo empty
// - low address bit selects command or data
// - transmission starts once dma feeds buffer
module sdl_link_channel #(
    parameter int FIFO_DEPTH = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [sdl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic transmit_bit_clock,
    input wire logic receive_bit_clock,
    input wire logic rx_line_data,
    input wire logic clear_to_send_n,
    input wire logic carrier_sense_n,
    input wire logic early_line_activity_n,
    output logic tx_line_data,
    output logic request_to_send_n,
    output logic wait_request_n,
    output logic interrupt_n
);
    import sdl_pkg::*;

    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // pin synchronisers: bit 0 tx clock, 1 rx clock, 2 rx data, 3 cts, 4 carrier, 5 activity
    logic [5:0] s1_ff, s2_ff, s3_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_ff <= 6'h3F;
            s2_ff <= 6'h3F;
            s3_ff <= 6'h3F;
        end else begin
            s1_ff <= {early_line_activity_n, carrier_sense_n, clear_to_send_n,
                      rx_line_data, receive_bit_clock, transmit_bit_clock};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    wire tx_fall = s3_ff[0] & ~s2_ff[0];
    // sampling on the falling edge acts as the inverted receive clock
    wire rx_fall = s3_ff[1] & ~s2_ff[1];
    wire rx_bit = s2_ff[2];
    wire cts_n_s = s2_ff[3];
    wire dcd_n_s = s2_ff[4];
    wire ela_n_s = s2_ff[5];
    wire modem_chg = (s3_ff[3] ^ s2_ff[3]) | (s3_ff[4] ^ s2_ff[4]);

    // register bus decode
    wire data_acc = reg_addr[DATA_SEL];
    wire [2:0] idx = reg_addr[IDX_LO +: 3];
    wire cfg_wr = reg_wr & ~data_acc;
    wire cmd_wr = cfg_wr & (idx == IDX_CMD);
    wire cmd_undr = cmd_wr & (reg_wdata == CMD_RST_UNDERRUN);
    wire cmd_ext = cmd_wr & (reg_wdata == CMD_RST_EXT);
    wire cmd_err = cmd_wr & (reg_wdata == CMD_RST_ERR);
    wire cmd_next = cmd_wr & (reg_wdata == CMD_RX_NEXT);
    wire tx_wr = reg_wr & data_acc;

    logic [7:0] mode_ff, rxctl_ff, txctl_ff, station_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_ff <= REG_RST;
            rxctl_ff <= REG_RST;
            txctl_ff <= REG_RST;
            station_ff <= REG_RST;
        end else if (cfg_wr) begin
            if (idx == IDX_MODE) mode_ff <= reg_wdata;
            if (idx == IDX_RXCTL) rxctl_ff <= reg_wdata;
            if (idx == IDX_TXCTL) txctl_ff <= reg_wdata;
            if (idx == IDX_STATION) station_ff <= reg_wdata;
        end
    end

    wire tx_en = txctl_ff[TXCTL_EN];
    wire rx_en = rxctl_ff[RXCTL_EN];
    wire [1:0] rxi_mode = mode_ff[MODE_RXI_LO +: 2];
    // internal copy of the collision gate, so an ungated transceiver is still safe
    wire tx_go = txctl_ff[TXCTL_RTS] & ~cts_n_s & ela_n_s;

    // transmitter
    sdl_tx_t tx_state_ff, nxt_tx_state;
    logic [15:0] tx_sh_ff, nxt_tx_sh, tx_crc_ff, nxt_tx_crc;
    logic [4:0] tx_cnt_ff, nxt_tx_cnt;
    logic [2:0] tx_ones_ff, nxt_tx_ones;
    logic [7:0] tx_buf_ff;
    logic tx_full_ff, tx_line_ff, nxt_tx_line, undr_ff, nxt_undr, tx_load;

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_ones = tx_ones_ff;
        nxt_tx_crc = tx_crc_ff;
        nxt_tx_line = tx_line_ff;
        // clear first, so an underrun in the same cycle still sets the latch
        nxt_undr = undr_ff & ~cmd_undr;
        tx_load = 1'b0;
        if (tx_cnt_ff == 5'h00) begin
            nxt_tx_ones = 3'h0;
            nxt_tx_cnt = UNIT_BYTE;
            nxt_tx_sh = {8'h00, FLAG};
            case (tx_state_ff)
                TX_OFF: begin
                    if (tx_en) nxt_tx_state = TX_FLAG;
                    else nxt_tx_cnt = 5'h00;
                end
                TX_FLAG: begin
                    if (!tx_en) begin
                        nxt_tx_state = TX_OFF;
                        nxt_tx_cnt = 5'h00;
                        nxt_tx_line = 1'b1;
                    end else if (tx_full_ff && tx_go) begin
                        nxt_tx_state = TX_DATA;
                        nxt_tx_sh = {8'h00, tx_buf_ff};
                        nxt_tx_crc = CRC_PRESET;
                        tx_load = 1'b1;
                    end
                end
                TX_DATA: begin
                    nxt_tx_ones = tx_ones_ff;
                    if (tx_full_ff) begin
                        nxt_tx_sh = {8'h00, tx_buf_ff};
                        tx_load = 1'b1;
                    end else if (!undr_ff && txctl_ff[TXCTL_CRC]) begin
                        // underrun with latch reset and crc enabled closes the frame with its crc
                        nxt_tx_state = TX_CRC;
                        nxt_tx_sh = ~tx_crc_ff;
                        nxt_tx_cnt = UNIT_CRC;
                        nxt_undr = 1'b1;
                    end else begin
                        nxt_tx_state = TX_FLAG;
                        nxt_tx_ones = 3'h0;
                        nxt_undr = 1'b1;
                    end
                end
                default: nxt_tx_state = TX_FLAG;
            endcase
        end else if (tx_fall) begin
            if (tx_state_ff != TX_FLAG && tx_ones_ff == ONES_STUFF) begin
                nxt_tx_line = 1'b0;
                nxt_tx_ones = 3'h0;
            end else begin
                nxt_tx_line = tx_sh_ff[0];
                nxt_tx_sh = {1'b0, tx_sh_ff[15:1]};
                nxt_tx_cnt = tx_cnt_ff - 5'h01;
                nxt_tx_ones = tx_sh_ff[0] ? tx_ones_ff + 3'h1 : 3'h0;
                if (tx_state_ff == TX_DATA) nxt_tx_crc = crc_bit(tx_crc_ff, tx_sh_ff[0]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_ff <= TX_OFF;
            tx_sh_ff <= 16'h0000;
            tx_crc_ff <= CRC_PRESET;
            tx_cnt_ff <= 5'h00;
            tx_ones_ff <= 3'h0;
            tx_line_ff <= 1'b1;
            undr_ff <= 1'b1;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tx_sh_ff <= nxt_tx_sh;
            tx_crc_ff <= nxt_tx_crc;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_ones_ff <= nxt_tx_ones;
            tx_line_ff <= nxt_tx_line;
            undr_ff <= nxt_undr;
        end
    end

    // a host write wins over the shifter taking the byte
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_buf_ff <= 8'h00;
            tx_full_ff <= 1'b0;
        end else if (tx_wr) begin
            tx_buf_ff <= reg_wdata;
            tx_full_ff <= 1'b1;
        end else if (tx_load) begin
            tx_full_ff <= 1'b0;
        end
    end

    // receiver
    sdl_rx_t rx_state_ff, nxt_rx_state;
    logic [7:0] rx_hist_ff, nxt_rx_hist, rx_sh_ff, nxt_rx_sh, rx_byte;
    logic [2:0] rx_bits_ff, nxt_rx_bits, rx_ones_ff, nxt_rx_ones;
    logic [15:0] rx_crc_ff, nxt_rx_crc;
    logic rx_push, set_eof, set_crc, set_abort;
    wire [7:0] win = {rx_bit, rx_hist_ff[7:1]};

    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_hist = rx_hist_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_bits = rx_bits_ff;
        nxt_rx_ones = rx_ones_ff;
        nxt_rx_crc = rx_crc_ff;
        rx_byte = {rx_bit, rx_sh_ff[7:1]};
        rx_push = 1'b0;
        set_eof = 1'b0;
        set_crc = 1'b0;
        set_abort = 1'b0;
        if (!rx_en) begin
            nxt_rx_state = RX_HUNT;
        end else if (rx_fall) begin
            nxt_rx_hist = win;
            if (win == FLAG) begin
                if (rx_state_ff == RX_DATA && rx_bits_ff == RX_END_BITS) begin
                    set_eof = 1'b1;
                    set_crc = (rx_crc_ff != CRC_GOOD);
                end
                nxt_rx_state = RX_ADDR;
                nxt_rx_bits = 3'h0;
                nxt_rx_ones = 3'h0;
                nxt_rx_crc = CRC_PRESET;
            end else if (rx_ones_ff == ONES_ABORT && rx_bit) begin
                // seven ones: abort, reported as a break
                set_abort = (rx_state_ff != RX_HUNT);
                nxt_rx_state = RX_HUNT;
            end else if (rx_ones_ff >= ONES_STUFF) begin
                nxt_rx_ones = rx_bit ? ONES_ABORT : 3'h0;
            end else begin
                nxt_rx_ones = rx_bit ? rx_ones_ff + 3'h1 : 3'h0;
                nxt_rx_sh = rx_byte;
                nxt_rx_bits = rx_bits_ff + 3'h1;
                if (rx_bits_ff == RX_LAST_BIT) begin
                    nxt_rx_crc = crc_byte(rx_crc_ff, rx_byte);
                    case (rx_state_ff)
                        RX_ADDR: begin
                            if (rx_byte == station_ff) begin
                                nxt_rx_state = RX_DATA;
                                rx_push = 1'b1;
                            end else begin
                                nxt_rx_state = RX_SKIP;
                            end
                        end
                        RX_DATA: rx_push = 1'b1;
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_state_ff <= RX_HUNT;
            rx_hist_ff <= 8'h00;
            rx_sh_ff <= 8'h00;
            rx_bits_ff <= 3'h0;
            rx_ones_ff <= 3'h0;
            rx_crc_ff <= CRC_PRESET;
        end else begin
            rx_state_ff <= nxt_rx_state;
            rx_hist_ff <= nxt_rx_hist;
            rx_sh_ff <= nxt_rx_sh;
            rx_bits_ff <= nxt_rx_bits;
            rx_ones_ff <= nxt_rx_ones;
            rx_crc_ff <= nxt_rx_crc;
        end
    end

    // receive fifo; a byte arriving while full is dropped and flagged
    logic [7:0] rx_mem_ff [FIFO_DEPTH];
    logic [PTR_W-1:0] rd_ptr_ff, wr_ptr_ff;
    logic [CNT_W-1:0] rx_cnt_ff;
    wire rx_avail = (rx_cnt_ff != '0);
    wire rx_full = (rx_cnt_ff == CNT_W'(FIFO_DEPTH));
    wire rx_pop = reg_rd & data_acc & rx_avail;
    wire do_push = rx_push & ~rx_full;
    wire set_ovr = rx_push & rx_full;

    always_ff @(posedge clk) begin
        if (do_push) rx_mem_ff[wr_ptr_ff] <= rx_byte;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_ptr_ff <= '0;
            wr_ptr_ff <= '0;
            rx_cnt_ff <= '0;
        end else begin
            if (do_push) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (rx_pop) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            if (do_push && !rx_pop) rx_cnt_ff <= rx_cnt_ff + 1'b1;
            else if (rx_pop && !do_push) rx_cnt_ff <= rx_cnt_ff - 1'b1;
        end
    end

    // sticky conditions: hardware set wins over the clearing command
    logic eof_ff, crc_err_ff, ovr_ff, abort_ff, ext_pend_ff, first_pend_ff, armed_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            eof_ff <= 1'b0;
            crc_err_ff <= 1'b0;
            ovr_ff <= 1'b0;
            abort_ff <= 1'b0;
            ext_pend_ff <= 1'b0;
            first_pend_ff <= 1'b0;
            armed_ff <= 1'b1;
        end else begin
            eof_ff <= set_eof | (eof_ff & ~cmd_err);
            crc_err_ff <= set_crc | (crc_err_ff & ~cmd_err);
            ovr_ff <= set_ovr | (ovr_ff & ~cmd_err);
            abort_ff <= set_abort | (abort_ff & ~cmd_ext);
            ext_pend_ff <= modem_chg | set_abort | (ext_pend_ff & ~cmd_ext);
            first_pend_ff <= (do_push & armed_ff) | (first_pend_ff & ~cmd_next & ~rx_pop);
            armed_ff <= cmd_next | (armed_ff & ~do_push);
        end
    end

    // interrupt sources, gated by the master enable
    wire special = ovr_ff | eof_ff | crc_err_ff;
    wire rx_int = ((rxi_mode == RXI_FIRST) & first_pend_ff) | ((rxi_mode == RXI_ALL) & rx_avail)
        | ((rxi_mode != RXI_OFF) & special);
    wire ext_int = mode_ff[MODE_EXT_IE] & ext_pend_ff;
    wire any_int = mode_ff[MODE_MIE] & (rx_int | ext_int);

    // dma request: transmit wants an empty buffer, receive a held character
    wire dma_want = mode_ff[MODE_DMA_RX] ? rx_avail : (tx_en & ~tx_full_ff);
    wire dma_req = mode_ff[MODE_DMA_EN] & dma_want;

    logic [7:0] main_status;
    always_comb begin
        main_status = 8'h00;
        main_status[ST_RX_AVAIL] = rx_avail;
        main_status[ST_CRC_ERR] = crc_err_ff;
        main_status[ST_TX_EMPTY] = ~tx_full_ff;
        main_status[ST_CARRIER] = ~dcd_n_s;
        main_status[ST_EOF] = eof_ff;
        main_status[ST_CTS] = ~cts_n_s;
        main_status[ST_EOM] = undr_ff;
        main_status[ST_ABORT] = abort_ff;
    end

    logic [7:0] special_status, cfg_read, rd_value;
    always_comb begin
        special_status = 8'h00;
        special_status[SP_EOF] = eof_ff;
        special_status[SP_OVERRUN] = ovr_ff;
    end

    assign cfg_read = (idx == IDX_CMD) ? main_status :
                      (idx == IDX_SPECIAL) ? special_status :
                      (idx == IDX_RXCTL) ? rxctl_ff :
                      (idx == IDX_TXCTL) ? txctl_ff :
                      (idx == IDX_STATION) ? station_ff : 8'h00;
    assign rd_value = data_acc ? (rx_avail ? rx_mem_ff[rd_ptr_ff] : 8'h00) : cfg_read;

    logic [7:0] rdata_ff;
    logic rts_n_ff, wreq_n_ff, int_n_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff <= 8'h00;
            rts_n_ff <= 1'b1;
            wreq_n_ff <= 1'b1;
            int_n_ff <= 1'b1;
        end else begin
            rdata_ff <= reg_rd ? rd_value : 8'h00;
            rts_n_ff <= ~txctl_ff[TXCTL_RTS];
            wreq_n_ff <= ~dma_req;
            int_n_ff <= ~any_int;
        end
    end

    assign reg_rdata = rdata_ff;
    assign tx_line_data = tx_line_ff;
    assign request_to_send_n = rts_n_ff;
    assign wait_request_n = wreq_n_ff;
    assign interrupt_n = int_n_ff;
endmodule

// ==== verification/sdl_checker.sv ====
`timescale 1ns/1ps
module sdl_checker #(
    parameter int FIFO_DEPTH = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [sdl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic carrier_sense_n,
    input wire logic tx_line_data,
    input wire logic request_to_send_n,
    input wire logic wait_request_n
);
    import sdl_pkg::*;
    logic [7:0] mode_ff;
    logic [7:0] txctl_ff;
    logic [8:0] dis_cnt_ff;
    wire logic wr_mode = reg_wr && reg_addr == {IDX_MODE, 1'b0};
    wire logic wr_txctl = reg_wr && reg_addr == {IDX_TXCTL, 1'b0};
    wire logic wr_data = reg_wr && reg_addr[DATA_SEL];
    wire logic rd_status = reg_rd && reg_addr == {IDX_CMD, 1'b0};
    wire logic wr_c0 = reg_wr && reg_addr == {IDX_CMD, 1'b0} && reg_wdata == CMD_RST_UNDERRUN;
    wire logic [7:0] nxt_mode = wr_mode ? reg_wdata : mode_ff;
    wire logic [7:0] nxt_txctl = wr_txctl ? reg_wdata : txctl_ff;
    // saturating count of cycles with the transmitter off; the shifter ends its unit first
    wire logic [8:0] nxt_dis_cnt = txctl_ff[TXCTL_EN] ? 9'h000 :
        dis_cnt_ff + {8'h00, dis_cnt_ff != 9'h1FF};
    always_ff @(posedge clk) begin
        mode_ff <= reset ? REG_RST : nxt_mode;
        txctl_ff <= reset ? REG_RST : nxt_txctl;
        dis_cnt_ff <= reset ? 9'h000 : nxt_dis_cnt;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_unmapped;
        reg_rd && reg_addr == 4'hE |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_c0;
        wr_c0 ##[1:2] rd_status |=> !reg_rdata[ST_EOM];
    endproperty
    a_c0: assert property (p_c0) else $error("underrun latch not cleared");
    property p_d2;
        wr_data ##[1:2] rd_status |=> !reg_rdata[ST_TX_EMPTY];
    endproperty
    a_d2: assert property (p_d2) else $error("tx empty still set after write");
    property p_tx_req;
        mode_ff[MODE_DMA_EN] && !mode_ff[MODE_DMA_RX] && wr_data && !wait_request_n
            |-> ##[1:3] wait_request_n;
    endproperty
    a_tx_req: assert property (p_tx_req) else $error("tx request kept after write");
    property p_dma_off;
        !mode_ff[MODE_DMA_EN] && !$past(mode_ff[MODE_DMA_EN]) |-> wait_request_n;
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("request without dma");
    property p_rts;
        wr_txctl |-> ##2 request_to_send_n == !$past(reg_wdata[TXCTL_RTS], 2);
    endproperty
    a_rts: assert property (p_rts) else $error("request to send wrong");
    property p_tx_idle;
        dis_cnt_ff == 9'h1FF |-> tx_line_data;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("line not idle");
    property p_carrier;
        carrier_sense_n [*4] ##0 rd_status |=> !reg_rdata[ST_CARRIER];
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier status wrong");
    property p_rst;
        $fell(reset) |-> wait_request_n && request_to_send_n && tx_line_data;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule
bind sdl_link_channel sdl_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .carrier_sense_n(carrier_sense_n),
    .tx_line_data(tx_line_data), .request_to_send_n(request_to_send_n),
    .wait_request_n(wait_request_n)
);

// ==== verification/sdl_xcv_model.sv ====
`timescale 1ns/1ps
module sdl_xcv_model (
    output logic transmit_bit_clock,
    output logic receive_bit_clock,
    output logic rx_line_data,
    output logic clear_to_send_n,
    output logic carrier_sense_n,
    output logic early_line_activity_n,
    input wire logic tx_line_data,
    input wire logic request_to_send_n,
    input wire logic line_busy
);
    logic rx_active = 1'b0;
    logic [7:0] tx_sh = 8'h00;
    logic [15:0] last_fcs = 16'h0000;
    int flag_cnt = 0;
    int ones = 0;
    // other stations' traffic shows as activity, our own transmit never does
    assign early_line_activity_n = !(line_busy || rx_active);
    assign carrier_sense_n = !rx_active;
    assign clear_to_send_n = request_to_send_n || !early_line_activity_n;
    initial begin
        transmit_bit_clock = 1'b0;
        receive_bit_clock = 1'b0;
        rx_line_data = 1'b1;
        #7;
        forever #80 transmit_bit_clock = ~transmit_bit_clock;
    end
    always @(posedge transmit_bit_clock) begin
        tx_sh = {tx_line_data, tx_sh[7:1]};
        if (tx_sh == 8'h7E) begin
            flag_cnt++;
        end
    end
    // launched on the rising edge, so the channel must capture on the falling one
    task automatic put_bit(input logic b);
        rx_line_data = b;
        receive_bit_clock = 1'b1;
        #80 receive_bit_clock = 1'b0;
        #80;
    endtask
    task automatic put_bits(input logic [15:0] v, input int n, input logic stuff);
        for (int i = 0; i < n; i++) begin
            put_bit(v[i]);
            ones = (v[i] && stuff) ? ones + 1 : 0;
            if (ones == 5) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask
    task automatic send_frame(input logic [7:0] addr, input logic bad);
        logic [15:0] c;
        c = sdl_pkg::CRC_PRESET;
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ addr[i]) ? sdl_pkg::CRC_POLY : 16'h0000);
        end
        last_fcs = ~c ^ {15'h0000, bad};
        rx_active = 1'b1;
        #400;
        put_bits(16'h007E, 8, 1'b0);
        put_bits({8'h00, addr}, 8, 1'b1);
        put_bits(last_fcs, 16, 1'b1);
        put_bits(16'h007E, 8, 1'b0);
        rx_active = 1'b0;
        rx_line_data = ~rx_line_data;
        #400;
    endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import sdl_pkg::*;
    logic clk, reset, reg_wr, reg_rd, line_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, s, d;
    wire logic [7:0] reg_rdata;
    wire logic tbc, rbc, rxd, cts_n, crs_n, act_n, txd, rts_n, wreq_n, int_n;
    int failures = 0;
    int samples_checked = 0;
    sdl_link_channel #(.FIFO_DEPTH(3)) dut_u (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transmit_bit_clock(tbc),
        .receive_bit_clock(rbc), .rx_line_data(rxd), .clear_to_send_n(cts_n),
        .carrier_sense_n(crs_n), .early_line_activity_n(act_n), .tx_line_data(txd),
        .request_to_send_n(rts_n), .wait_request_n(wreq_n), .interrupt_n(int_n)
    );
    sdl_xcv_model xcv_u (
        .transmit_bit_clock(tbc), .receive_bit_clock(rbc), .rx_line_data(rxd),
        .clear_to_send_n(cts_n), .carrier_sense_n(crs_n), .early_line_activity_n(act_n),
        .tx_line_data(txd), .request_to_send_n(rts_n), .line_busy(line_busy)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // bounded status poll; running out ends the run
    task automatic poll(input int b, input logic v);
        for (int n = 0; n < 500; n++) begin
            rd(4'h0, s);
            if (s[b] === v) begin
                return;
            end
        end
        $display("mismatch t=%0t got=%h exp=%h", $time, s[b], v);
        failures++;
        final_report();
    endtask
    task automatic t_reset();
        wr(4'h0, CMD_RST_EXT);
        rd(4'h0, s);
        check(s & 8'h45, 8'h44);
        rd(4'hE, s);
        check(s, 8'h00);
        wr(4'h0, CMD_RST_UNDERRUN);
        rd(4'h0, s);
        check(s[ST_EOM], 1'b0);
    endtask
    task automatic t_tx();
        int f;
        line_busy <= 1'b1;
        wr(4'h2, 8'h80);
        wr(4'hA, 8'h0B);
        repeat (200) @(posedge clk);
        check(xcv_u.flag_cnt > 0, 1'b1);
        check(wreq_n, 1'b0);
        wr(4'h1, 8'h5A);
        rd(4'h0, s);
        check(s[ST_TX_EMPTY], 1'b0);
        check(wreq_n, 1'b1);
        repeat (400) @(posedge clk);
        rd(4'h0, s);
        check(s[ST_TX_EMPTY], 1'b0);
        line_busy <= 1'b0;
        poll(ST_TX_EMPTY, 1'b1);
        repeat (2) @(posedge clk);
        check(wreq_n, 1'b0);
        poll(ST_EOM, 1'b1);
        f = xcv_u.flag_cnt;
        repeat (300) @(posedge clk);
        check(xcv_u.flag_cnt > f, 1'b1);
        wr(4'hA, 8'h00);
        wr(4'h2, 8'h00);
    endtask
    task automatic t_rx();
        logic [7:0] e [3];
        wr(4'hC, 8'h02);
        wr(4'h6, 8'h01);
        wr(4'h2, 8'hA0);
        xcv_u.send_frame(8'h03, 1'b0);
        rd(4'h0, s);
        check(s[ST_RX_AVAIL], 1'b0);
        check(wreq_n, 1'b1);
        xcv_u.send_frame(8'h02, 1'b0);
        e = '{8'h02, xcv_u.last_fcs[7:0], xcv_u.last_fcs[15:8]};
        check(wreq_n, 1'b0);
        rd(4'h0, s);
        check(s & 8'h13, 8'h11);
        for (int i = 0; i < 3; i++) begin
            rd(4'h1, d);
            check(d, e[i]);
            rd(4'h0, s);
            check(s[ST_RX_AVAIL], i < 2);
        end
        check(wreq_n, 1'b1);
        wr(4'h0, CMD_RST_ERR);
        xcv_u.send_frame(8'h02, 1'b1);
        rd(4'h0, s);
        check(s[ST_CRC_ERR], 1'b1);
        wr(4'h2, 8'h1A);
        repeat (2) @(posedge clk);
        check(int_n, 1'b0);
        wr(4'h2, 8'h03);
        repeat (2) @(posedge clk);
        check(int_n, 1'b0);
    endtask
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        line_busy = 1'b0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        final_report();
    end
    initial begin
        #2000000;
        failures++;
        final_report();
    end
endmodule
